// file: logic/acq_trig_pkg.sv
// constants and carrier types for the acquisition trigger controller
// assumes a 50 MHz system clock and a 0.1 ms delay resolution
package acq_trig_pkg;
   // ==========================================================
   // bus map
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] ANGLE_OFS     = 8'h04;
   localparam logic [7:0] DELAY_OFS     = 8'h08;
   localparam logic [7:0] SETVOLT_OFS   = 8'h0c;
   localparam logic [7:0] STATUS_OFS    = 8'h10;
   localparam logic [7:0] CAPCOUNT_OFS  = 8'h14;
   localparam logic [7:0] CMD_OFS       = 8'h18;
   localparam logic [7:0] WINDOW_OFS    = 8'h1c;
   localparam logic [7:0] RDADDR_OFS    = 8'h20;
   localparam logic [7:0] RDDATA_OFS    = 8'h24;
   // ctrl field positions
   localparam int CTRL_REARM_BIT  = 0;
   localparam int CTRL_SRC_LSB    = 1;
   localparam int CTRL_PHSEL_LSB  = 3;
   localparam int CTRL_GEN_BIT    = 5;
   localparam int CTRL_THREE_BIT  = 6;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] DELAY_RESET   = 32'h0000_0000;
   localparam logic [31:0] WINDOW_RESET  = 32'h0000_0400;
   // ==========================================================
   // timing
   localparam int    CLK_HZ          = 50_000_000;
   localparam real   DELAY_STEP_MS   = 0.1;
   localparam int    STEP_CYCLES     = int'(DELAY_STEP_MS * CLK_HZ / 1000.0);
   localparam int    DELAY_MAX_STEPS = 10000;            // 1000.0 ms
   localparam real   REFRESH_S       = 1.0;
   localparam int    REFRESH_CYCLES  = int'(REFRESH_S * CLK_HZ);
   // pre-trigger depth limits in 0.1 ms steps: min/max per generation and phase mode
   localparam int    PRE_G1_1P_MAX   = 10400;            // 1040 msec
   localparam int    PRE_G1_3P_MAX   = 31200;            // 3120 msec
   localparam int    PRE_G2_1P_MAX   = 4260;             // 426 msec
   localparam int    PRE_G2_3P_MAX   = 12800;            // 1280 msec
   localparam int    PRE_G1_1P_MIN   = 1040;             // 104 msec
   localparam int    PRE_G1_3P_MIN   = 3120;             // 312 msec
   localparam int    PRE_G2_1P_MIN   = 426;              // 42.6 msec
   localparam int    PRE_G2_3P_MIN   = 1280;             // 128 msec
   // phase offsets of B and C relative to the angle setting, in degrees
   localparam logic [8:0] PH_A_OFS = 9'd0;
   localparam logic [8:0] PH_B_OFS = 9'd240;
   localparam logic [8:0] PH_C_OFS = 9'd120;
   localparam logic [8:0] DEG_FULL = 9'd360;

   typedef enum logic [1:0] {SRC_INSTANT, SRC_ANGLE, SRC_VSTEP} trig_src_t;
   typedef enum logic [1:0] {PH_A, PH_B, PH_C, PH_ALL} phase_sel_t;

   typedef struct packed {
      logic [8:0]  angle;      // degrees 0..359, phase A
      logic [23:0] volts;
      phase_sel_t  phSel;
   } vstep_t;

   // magnitude of the signed delay in steps
   function automatic logic [15:0] delayMag(input logic [31:0] d);
      logic [31:0] m;
      m = d[31] ? (~d + 32'd1) : d;
      return m[15:0];
   endfunction
endpackage

// file: logic/acquisition_trigger_control.sv
// acquisition trigger and arming controller with axi4-lite registers
// assumes synchronous sample stream, phase angle and relay inputs on sys_clk
//
// Functional notes
// - one-shot: arm once per start, capture on trigger, then idle
// - re-arm mode: re-arm after each trigger, no new start needed
// - re-arm mode presents a new result about once per second
// - instant source triggers on start; bus acquire command is identical
// - instant source never waits on any condition
// - angle source waits for phase A to reach programmed angle
// - angle always refers to phase A; B, C offsets 240 and 120
// - angle trigger uses first matching crossing after start only
// - voltage step programs output and triggers at the same instant
// - single phase selected reprograms that phase; all reprograms three
// - voltage step with relay open arms and fires when relay closes
// - voltage step with relay closed fires at once
// - positive delay postpones window; trigger sample excluded
// - positive delay 0 to 1000 ms in 0.1 ms steps
// - negative delay gives pre-trigger data, limited per generation and phase mode
// - first generation single-phase pre-trigger 104 to 1040 ms; only the 1040 ms ceiling is enforced, no minimum
// - first generation three-phase pre-trigger 312 to 3120 ms; only the 3120 ms ceiling is enforced, no minimum
// - second generation single-phase pre-trigger 42.6 to 426 ms; only the 426 ms ceiling is enforced, no minimum
// - second generation three-phase pre-trigger 128 to 1280 ms; only the 1280 ms ceiling is enforced, no minimum
`timescale 1ns/1ps
module acquisition_trigger_control
   import acq_trig_pkg::*;
#(
   parameter int SW    = 16,
   parameter int DEPTH = 1024,
   parameter int REFRESH = REFRESH_CYCLES,
   parameter int STEPC   = STEP_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        startReq,
   input  wire logic [8:0]  phaseAngle,
   input  wire logic        relayClosed,
   input  wire logic        sampleValid,
   input  wire logic [SW-1:0] sampleData,
   output logic             setVoltStrobe,
   output logic [2:0]       setVoltPhases,
   output vstep_t           setVoltValue,
   output logic             trigPulse,
   output logic             armed,
   output logic             resultReady
);
   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // register file
   logic [31:0] ctrl_q, angle_q, delay_q, volts_q, window_q, rdAddr_q;
   logic [31:0] capCount_q;
   logic        busAcq_q;
   logic        awTaken_q, wTaken_q;
   logic [7:0]  awAddr_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic [SW-1:0] ringOut;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   wire doWrite = awTaken_q && wTaken_q && !s_axi_bvalid;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         awTaken_q <= 1'b0;
         wTaken_q  <= 1'b0;
         awAddr_q  <= 8'h00;
         wData_q   <= 32'h0000_0000;
         wStrb_q   <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awTaken_q <= 1'b1;
            awAddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wTaken_q <= 1'b1;
            wData_q  <= s_axi_wdata;
            wStrb_q  <= s_axi_wstrb;
         end
         if (doWrite) begin
            awTaken_q    <= 1'b0;
            wTaken_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb s_axi_awready = !awTaken_q && !s_axi_bvalid;
   always_comb s_axi_wready  = !wTaken_q && !s_axi_bvalid;

   wire wrMapped = awAddr_q inside {CTRL_OFS, ANGLE_OFS, DELAY_OFS, SETVOLT_OFS, CMD_OFS,
                                    WINDOW_OFS, RDADDR_OFS};

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_axi_bresp <= 2'h0;
         ctrl_q   <= CTRL_RESET;
         angle_q  <= 32'h0000_0000;
         delay_q  <= DELAY_RESET;
         volts_q  <= 32'h0000_0000;
         window_q <= WINDOW_RESET;
         rdAddr_q <= 32'h0000_0000;
         busAcq_q <= 1'b0;
      end else begin
         busAcq_q <= 1'b0;
         if (doWrite) begin
            s_axi_bresp <= wrMapped ? 2'h0 : 2'h2;
            case (awAddr_q)
               CTRL_OFS:    ctrl_q   <= mergeBytes(ctrl_q, wData_q, wStrb_q);
               ANGLE_OFS:   angle_q  <= mergeBytes(angle_q, wData_q, wStrb_q);
               DELAY_OFS:   delay_q  <= mergeBytes(delay_q, wData_q, wStrb_q);
               SETVOLT_OFS: volts_q  <= mergeBytes(volts_q, wData_q, wStrb_q);
               WINDOW_OFS:  window_q <= mergeBytes(window_q, wData_q, wStrb_q);
               RDADDR_OFS:  rdAddr_q <= mergeBytes(rdAddr_q, wData_q, wStrb_q);
               CMD_OFS:     busAcq_q <= wStrb_q[0] & wData_q[0];
               default:     ;
            endcase
         end
      end
   end

   // ==========================================================
   // trigger engine
   typedef enum logic [2:0] {IDLE, WAIT_TRIG, POST_HOLD, FILL, HOLDOFF} acq_state_t;
   acq_state_t state_q;

   wire        rearm   = ctrl_q[CTRL_REARM_BIT];
   trig_src_t  src;
   phase_sel_t phSel;
   always_comb src   = trig_src_t'(ctrl_q[CTRL_SRC_LSB +: 2]);
   always_comb phSel = phase_sel_t'(ctrl_q[CTRL_PHSEL_LSB +: 2]);
   wire start = startReq | busAcq_q;

   // pre-trigger ceiling per generation and phase mode, in 0.1 ms steps
   function automatic logic [15:0] preMax(input logic gen2, input logic three);
      case ({gen2, three})
         2'b00:   return 16'(PRE_G1_1P_MAX);
         2'b01:   return 16'(PRE_G1_3P_MAX);
         2'b10:   return 16'(PRE_G2_1P_MAX);
         default: return 16'(PRE_G2_3P_MAX);
      endcase
   endfunction

   logic [15:0] preSteps, postSteps, dMag;
   always_comb begin
      dMag      = delayMag(delay_q);
      preSteps  = 16'h0000;
      postSteps = 16'h0000;
      if (delay_q[31]) begin
         preSteps = (dMag > preMax(ctrl_q[CTRL_GEN_BIT], ctrl_q[CTRL_THREE_BIT]))
                  ? preMax(ctrl_q[CTRL_GEN_BIT], ctrl_q[CTRL_THREE_BIT]) : dMag;
      end else begin
         postSteps = (dMag > 16'(DELAY_MAX_STEPS)) ? 16'(DELAY_MAX_STEPS) : dMag;
      end
   end

   // phase A crossing detector: angle for phase A is the setting itself
   logic [8:0] prevAngle_q;
   logic       primed_q;
   wire [8:0]  tgt = angle_q[8:0] + PH_A_OFS;
   wire crossed = (prevAngle_q <= phaseAngle)
                ? (tgt > prevAngle_q && tgt <= phaseAngle)
                : (tgt > prevAngle_q || tgt <= phaseAngle);

   logic fire;
   always_comb begin
      fire = 1'b0;
      case (src)
         SRC_INSTANT: fire = 1'b1;
         SRC_ANGLE:   fire = primed_q && crossed;
         SRC_VSTEP:   fire = relayClosed;
         default:     fire = 1'b1;
      endcase
   end

   logic stepTick;
   step_divider #(.COUNT(STEPC)) u_step (
      .sys_clk(sys_clk),
      .reset  (reset),
      .tick   (stepTick)
   );

   logic [AW-1:0] wrPtr_q, winStart_q;
   logic [15:0]   stepCnt_q;
   logic [31:0]   fillCnt_q, refresh_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prevAngle_q <= 9'd0;
      end else begin
         prevAngle_q <= phaseAngle;
      end
   end

   // ring keeps filling so pre-trigger samples exist
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wrPtr_q <= '0;
      end else if (sampleValid) begin
         wrPtr_q <= wrPtr_q + AW'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q       <= IDLE;
         primed_q      <= 1'b0;
         stepCnt_q     <= 16'h0000;
         fillCnt_q     <= 32'h0000_0000;
         refresh_q     <= 32'h0000_0000;
         winStart_q    <= '0;
         trigPulse     <= 1'b0;
         setVoltStrobe <= 1'b0;
         setVoltPhases <= 3'b000;
         setVoltValue  <= '0;
         armed         <= 1'b0;
         resultReady   <= 1'b0;
         capCount_q    <= 32'h0000_0000;
      end else begin
         trigPulse     <= 1'b0;
         setVoltStrobe <= 1'b0;
         case (state_q)
            IDLE: begin
               if (start) begin
                  state_q  <= WAIT_TRIG;
                  armed    <= 1'b1;
                  primed_q <= 1'b0;
                  resultReady <= 1'b0;
               end
            end
            WAIT_TRIG: begin
               primed_q <= 1'b1;
               if (fire) begin
                  trigPulse <= 1'b1;
                  if (src == SRC_VSTEP) begin
                     setVoltStrobe <= 1'b1;
                     setVoltPhases <= (phSel == PH_ALL) ? 3'b111
                                    : 3'(3'b001 << phSel);
                     setVoltValue  <= '{angle: angle_q[8:0], volts: volts_q[23:0],
                                        phSel: phSel};
                  end
                  // negative delay backs the window into stored samples
                  winStart_q <= wrPtr_q - AW'(preSteps);
                  stepCnt_q  <= postSteps;
                  fillCnt_q  <= 32'h0000_0000;
                  state_q    <= (postSteps != 16'h0000) ? POST_HOLD : FILL;
               end
            end
            POST_HOLD: begin
               if (stepTick) begin
                  stepCnt_q <= stepCnt_q - 16'h0001;
                  if (stepCnt_q == 16'h0001) begin
                     winStart_q <= wrPtr_q + AW'(1);
                     state_q    <= FILL;
                  end
               end
            end
            FILL: begin
               if (sampleValid) fillCnt_q <= fillCnt_q + 32'h0000_0001;
               if (fillCnt_q + 32'(preSteps) >= window_q) begin
                  resultReady <= 1'b1;
                  capCount_q  <= capCount_q + 32'h0000_0001;
                  refresh_q   <= 32'h0000_0000;
                  if (rearm) begin
                     state_q <= HOLDOFF;
                  end else begin
                     state_q <= IDLE;
                     armed   <= 1'b0;
                  end
               end
            end
            HOLDOFF: begin
               // paces refreshes; display cannot use faster updates
               refresh_q <= refresh_q + 32'h0000_0001;
               if (refresh_q >= 32'(REFRESH - 1)) begin
                  state_q  <= WAIT_TRIG;
                  primed_q <= 1'b0;
               end
            end
            default: state_q <= IDLE;
         endcase
      end
   end

   sample_ring #(.WIDTH(SW), .DEPTH(DEPTH)) u_ring (
      .sys_clk(sys_clk),
      .wrEn   (sampleValid),
      .wrAddr (wrPtr_q),
      .wrData (sampleData),
      .rdAddr (winStart_q + rdAddr_q[AW-1:0]),
      .rdData (ringOut)
   );

   // ==========================================================
   // read channel, one wait cycle for the ring
   logic [7:0] arAddr_q;
   logic       rdPend_q;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
         arAddr_q      <= 8'h00;
         rdPend_q      <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            arAddr_q      <= s_axi_araddr;
            s_axi_arready <= 1'b0;
            rdPend_q      <= 1'b1;
         end else if (rdPend_q) begin
            rdPend_q     <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (arAddr_q)
               CTRL_OFS:     s_axi_rdata <= ctrl_q;
               ANGLE_OFS:    s_axi_rdata <= angle_q;
               DELAY_OFS:    s_axi_rdata <= delay_q;
               SETVOLT_OFS:  s_axi_rdata <= volts_q;
               STATUS_OFS:   s_axi_rdata <= {28'h0, relayClosed, resultReady, armed,
                                             state_q == WAIT_TRIG};
               CAPCOUNT_OFS: s_axi_rdata <= capCount_q;
               CMD_OFS:      s_axi_rdata <= 32'h0000_0000;
               WINDOW_OFS:   s_axi_rdata <= window_q;
               RDADDR_OFS:   s_axi_rdata <= rdAddr_q;
               RDDATA_OFS:   s_axi_rdata <= 32'(ringOut);
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // checks
   one_shot_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == FILL && !rearm && fillCnt_q + 32'(preSteps) >= window_q)
      |=> (state_q == IDLE && !armed)) else $error("one-shot did not go idle");
   rearm_loop_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == HOLDOFF && refresh_q >= 32'(REFRESH - 1)) |=> state_q == WAIT_TRIG)
      else $error("re-arm did not return to waiting");
   instant_fire_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == WAIT_TRIG && src == SRC_INSTANT) |=> trigPulse)
      else $error("instant source did not fire");
   start_arm_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == IDLE && start) |=> (armed && state_q == WAIT_TRIG))
      else $error("start did not arm");
   relay_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == WAIT_TRIG && src == SRC_VSTEP && !relayClosed) |=> !trigPulse)
      else $error("voltage step fired with relay open");
   step_together_a: assert property (@(posedge sys_clk) disable iff (reset)
      setVoltStrobe |-> trigPulse) else $error("voltage step without trigger");
   all_phase_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == WAIT_TRIG && fire && src == SRC_VSTEP && phSel == PH_ALL)
      |=> setVoltPhases == 3'b111) else $error("all phases not programmed");
   angle_first_a: assert property (@(posedge sys_clk) disable iff (reset)
      (state_q == WAIT_TRIG && !primed_q && src == SRC_ANGLE) |=> !trigPulse)
      else $error("angle trigger fired on stale crossing");
endmodule

// file: logic/sample_ring.sv
// circular sample store with registered read port
// assumes a single clock; write every cycle the writer enables it
`timescale 1ns/1ps
module sample_ring #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 1024,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             sys_clk,
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule

// file: logic/step_divider.sv
// divider giving one-cycle enable pulses
// assumes sys_clk and active-high async reset
`timescale 1ns/1ps
module step_divider #(
   parameter int COUNT = 5000
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   output logic      tick
);
   logic [31:0] cnt_q;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= 32'h0000_0000;
         tick  <= 1'b0;
      end else if (cnt_q == 32'(COUNT - 1)) begin
         cnt_q <= 32'h0000_0000;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
         tick  <= 1'b0;
      end
   end
endmodule

// file: verif/acquisition_trigger_control_tb.sv
// self-checking bench for the acquisition trigger controller
// assumes operator_stub as far side and short REFRESH and STEPC values
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
   $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module acquisition_trigger_control_tb;
   import acq_trig_pkg::*;
   logic sys_clk = 1'b0, reset = 1'b1, fire = 1'b0, closeRelay = 1'b0, spin = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, startReq, relayClosed, sampleValid;
   logic [1:0] bresp, rresp;
   logic [8:0] phaseAngle;
   logic [15:0] sampleData;
   logic setVoltStrobe, trigPulse, armed, resultReady, strobeHit;
   logic [2:0] setVoltPhases, phHit;
   vstep_t setVoltValue, valHit;
   int cyc = 0, startCyc = 0, trigCyc = 0, trigCnt = 0, n_errors = 0, compares = 0;
   logic [1:0] rsp;
   always #10 sys_clk = ~sys_clk;
   operator_stub u_operator_stub (.sys_clk(sys_clk), .reset(reset), .fire(fire),
      .closeRelay(closeRelay), .spin(spin), .startReq(startReq), .phaseAngle(phaseAngle),
      .relayClosed(relayClosed), .sampleValid(sampleValid), .sampleData(sampleData));
   acquisition_trigger_control #(.REFRESH(20), .STEPC(4)) u_acquisition_trigger_control (
      .sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .startReq(startReq), .phaseAngle(phaseAngle), .relayClosed(relayClosed),
      .sampleValid(sampleValid), .sampleData(sampleData), .setVoltStrobe(setVoltStrobe),
      .setVoltPhases(setVoltPhases), .setVoltValue(setVoltValue), .trigPulse(trigPulse),
      .armed(armed), .resultReady(resultReady));
   // ==========================================================
   // monitor and watchdog
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (startReq) startCyc <= cyc;
      if (trigPulse) begin
         trigCnt <= trigCnt + 1;
         trigCyc <= cyc;
         strobeHit <= setVoltStrobe;
         phHit <= setVoltPhases;
         valHit <= setVoltValue;
      end
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   // ==========================================================
   // bus and helper tasks
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge sys_clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid && bready) begin bready <= 0; rsp = bresp; end
      end while (awvalid || wvalid || bready);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge sys_clk);
         if (arready) arvalid <= 0;
         if (rvalid && rready) begin rready <= 0; d = rdata; rsp = rresp; end
      end while (arvalid || rready);
   endtask
   task automatic pulse();
      @(posedge sys_clk); fire <= 1;
      @(posedge sys_clk); fire <= 0;
   endtask
   task automatic wait_trig(input int n0);
      for (int t = 0; t < 300 && trigCnt == n0; t++) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(trigCnt, n0 + 1)
   endtask
   task automatic wait_done();
      for (int t = 0; t < 300 && resultReady !== 1'b1; t++) @(negedge sys_clk);
      `CHK(resultReady, 1'b1)
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      logic [31:0] d;
      axr(CTRL_OFS, d); `CHK(d, CTRL_RESET)
      axr(WINDOW_OFS, d); `CHK(d, WINDOW_RESET)
      axr(8'hfc, d); `CHK(rsp, 2'b10)
      axw(8'hfc, 32'h1); `CHK(rsp, 2'b10)
      axw(WINDOW_OFS, 32'h10); axr(WINDOW_OFS, d); `CHK(d, 32'h10)
   endtask
   task automatic t_instant();
      int n;
      axw(CTRL_OFS, 32'h0); n = trigCnt;
      pulse(); wait_trig(n);
      `CHK(trigCyc - startCyc, 2)
      wait_done(); `CHK(armed, 1'b0)
      repeat (60) @(negedge sys_clk);
      `CHK(trigCnt, n + 1)
      axw(CMD_OFS, 32'h1); wait_trig(n + 1);
      wait_done(); `CHK(armed, 1'b0)
   endtask
   task automatic t_angle();
      int n;
      axw(CTRL_OFS, 32'h2); axw(ANGLE_OFS, 32'd90);
      spin <= 1; n = trigCnt;
      for (int t = 0; t < 60 && phaseAngle != 9'd100; t++) @(posedge sys_clk);
      fire <= 1; @(posedge sys_clk); fire <= 0;
      wait_trig(n);
      // start seen at 110 degrees; the 90 degree crossing is one turn on
      `CHK((trigCyc - startCyc) inside {[33:39]}, 1'b1)
      wait_done(); @(posedge sys_clk); spin <= 0;
   endtask
   task automatic t_vstep();
      int n;
      axw(SETVOLT_OFS, 32'h0001_2345);
      for (int ph = 0; ph < 4; ph++) begin
         axw(CTRL_OFS, 32'h4 | (ph << 3)); n = trigCnt;
         pulse(); repeat (6) @(negedge sys_clk);
         `CHK(armed, 1'b1)
         `CHK(trigCnt, n)
         @(posedge sys_clk); closeRelay <= 1;
         wait_trig(n);
         `CHK(strobeHit, 1'b1)
         `CHK(phHit, (ph == 3) ? 3'h7 : 3'(1 << ph))
         `CHK(valHit.volts, 24'h01_2345)
         `CHK(valHit.phSel, 2'(ph))
         wait_done();
         if (ph < 3) begin @(posedge sys_clk); closeRelay <= 0; end
      end
      n = trigCnt; pulse(); wait_trig(n);
      `CHK(trigCyc - startCyc, 2)
      wait_done(); @(posedge sys_clk); closeRelay <= 0;
   endtask
   // five steps of hold, then four and then many pre-trigger samples
   task automatic t_delay();
      int n, k;
      axw(CTRL_OFS, 32'h0);
      for (int i = 0; i < 3; i++) begin
         axw(DELAY_OFS, (i == 0) ? 32'h5 : (i == 1) ? 32'hffff_fffc : 32'hffff_f830);
         n = trigCnt;
         pulse(); wait_trig(n);
         for (k = 0; k < 300 && resultReady !== 1'b1; k++) @(negedge sys_clk);
         if (i == 0) begin
            `CHK(k inside {[32:35]}, 1'b1)
         end else begin
            `CHK(k, (i == 1) ? 11 : 0)
         end
      end
      axw(DELAY_OFS, 32'h0);
   endtask
   task automatic t_rearm();
      int n, last;
      axw(CTRL_OFS, 32'h1); n = trigCnt;
      pulse(); wait_trig(n); last = trigCyc;
      for (int k = 1; k < 4; k++) begin
         wait_trig(n + k);
         `CHK((trigCyc - last) >= 20, 1'b1)
         last = trigCyc;
      end
   endtask
   task automatic complete_run();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      reset <= 0;
      t_regs(); t_instant(); t_angle(); t_vstep(); t_delay(); t_rearm();
      complete_run();
   end
endmodule

// file: verif/operator_stub.sv
// far-side model: operator start, phase A angle, output relay, sample stream
// assumes the bench steers it by fire, closeRelay and spin on sys_clk
`timescale 1ns/1ps
module operator_stub (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       fire,
   input  wire logic       closeRelay,
   input  wire logic       spin,
   output logic            startReq,
   output logic [8:0]      phaseAngle,
   output logic            relayClosed,
   output logic            sampleValid,
   output logic [15:0]     sampleData
);
   // ==========================================================
   // operator and plant
   // coarse 10 degree steps keep one turn at 36 cycles
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         startReq    <= 1'b0;
         relayClosed <= 1'b0;
         phaseAngle  <= 9'h000;
         sampleValid <= 1'b0;
         sampleData  <= 16'h0000;
      end else begin
         startReq    <= fire;
         relayClosed <= closeRelay;
         if (spin) begin
            phaseAngle <= (phaseAngle >= 9'h15e) ? 9'h000 : phaseAngle + 9'h00a;
         end
         sampleValid <= 1'b1;
         sampleData  <= sampleData + 16'h0001;
      end
   end
endmodule
